// *** include/scss_pkg.sv ***
// constants, types and register map of the system clock source switch
package scss_pkg;

	// register byte addresses on the wishbone slave
	localparam logic [7:0] OSC_CTRL_ADDR    = 8'h00;
	localparam logic [7:0] SEC_TMR_CTRL_ADDR = 8'h04;

	// reset values
	localparam logic [7:0] OSC_CTRL_RST = 8'h00;
	localparam logic [7:0] SEC_TMR_RST  = 8'h00;
	localparam logic [7:0] PRIM_MODE_RST = 8'h00;

	// oscillator_control fields
	localparam int HALT_BIT    = 7;
	localparam int FREQ_HI     = 6;
	localparam int FREQ_LO     = 4;
	localparam int STARTUP_BIT = 3;
	localparam int STABLE_BIT  = 2;
	localparam int SCS_HI      = 1;
	localparam int SCS_LO      = 0;

	// secondary_timer_control fields
	localparam int SECONDARY_RUN_MODE_BIT = 6;
	localparam int SEC_EN_BIT  = 3;

	// internal_freq_select codes that bypass the postscaler
	localparam logic [2:0] FREQ_DIRECT_FAST = 3'h7;
	localparam logic [2:0] FREQ_DIRECT_SLOW = 3'h0;

	// clock_source_select codes
	localparam logic [1:0] SCS_PRIMARY   = 2'h0;
	localparam logic [1:0] SCS_SECONDARY = 2'h1;

	// edges of the new source counted before it clocks the system
	localparam logic [3:0] HOLD_EDGES = 4'h8;

	// index of each pin input in the synchroniser vector
	localparam int PIN_PRI  = 0;
	localparam int PIN_SEC  = 1;
	localparam int PIN_FAST = 2;
	localparam int PIN_SLOW = 3;
	localparam int PIN_OST  = 4;
	localparam int PIN_FSTB = 5;
	localparam int PIN_N    = 6;

	typedef enum logic [1:0] {
		SRC_PRI = 2'h0,
		SRC_SEC = 2'h1,
		SRC_INT = 2'h2
	} scss_src_t;

	// gray along primary -> hold -> managed -> sleep
	typedef enum logic [1:0] {
		ST_PRI   = 2'h0,
		ST_HOLD  = 2'h1,
		ST_PM    = 2'h3,
		ST_SLEEP = 2'h2
	} scss_state_t;

	typedef struct packed {
		logic       sys_clk_run;
		logic       cpu_clk_run;
		logic       prim_osc_en;
		logic       sec_osc_en;
		logic       fast_osc_en;
		logic       slow_osc_en;
		scss_src_t  src;
		logic [2:0] int_freq;
	} scss_clk_ctl_t;

endpackage

// *** verilog/scss_top.sv ***
// system clock source selection, glitch-free switch and power-managed gating
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps

module scss_top (
	input  wire logic                    clk_i,         // 200 MHz system clock
	input  wire logic                    rst_i,         // sync reset, any kind
	input  wire logic                    wb_cyc_i,      // wishbone cycle
	input  wire logic                    wb_stb_i,      // wishbone strobe
	input  wire logic                    wb_we_i,       // wishbone write
	input  wire logic [7:0]              wb_adr_i,      // byte address
	input  wire logic [3:0]              wb_sel_i,      // byte enables
	input  wire logic [31:0]             wb_dat_i,      // write data
	output logic      [31:0]             wb_dat_o,      // read data
	output logic                         wb_ack_o,      // wishbone ack
	input  wire logic [7:0]              cfg_prim_mode_i, // config byte
	input  wire logic                    sleep_exec_i,  // sleep instr pulse
	input  wire logic                    irq_wake_i,    // interrupt wake
	input  wire logic                    wdt_timeout_i, // watchdog time-out
	input  wire logic                    wdt_en_i,      // watchdog enabled
	input  wire logic                    fscm_en_i,     // fail-safe enabled
	input  wire logic                    prim_clk_i,    // primary osc pin
	input  wire logic                    sec_clk_i,     // secondary osc pin
	input  wire logic                    fast_clk_i,    // fast internal osc
	input  wire logic                    slow_clk_i,    // slow internal osc
	input  wire logic                    ost_done_i,    // start-up timer done
	input  wire logic                    fast_stable_i, // fast osc stable
	output logic      [7:0]              prim_mode_o,   // latched mode
	output scss_pkg::scss_clk_ctl_t      clk_ctl_o      // clock controls
);

	logic [scss_pkg::PIN_N-1:0] pin_v;
	logic [scss_pkg::PIN_N-1:0] sy1_r;
	logic [scss_pkg::PIN_N-1:0] sy2_r;
	logic [scss_pkg::PIN_N-1:0] sy3_r;
	logic [scss_pkg::PIN_N-1:0] stab_r;
	logic [scss_pkg::PIN_N-1:0] rise;

	logic                  halt_r;
	logic [2:0]            freq_r;
	logic [1:0]            scs_r;
	logic [7:0]            t1ctl_r;
	logic                  cfg_done_r;
	scss_pkg::scss_state_t state_r;
	scss_pkg::scss_state_t state_nxt;
	scss_pkg::scss_src_t   src_r;
	scss_pkg::scss_src_t   src_nxt;
	logic                  pm_halt_r;
	logic                  pm_halt_nxt;
	logic [3:0]            cnt_r;
	logic [3:0]            cnt_nxt;
	logic                  wake;
	logic                  new_rise;
	logic                  sleep_mode_req;
	scss_pkg::scss_src_t   req_src;
	logic                  st_startup;
	logic                  st_stable;
	logic                  st_secrun;
	logic                  wb_req;
	logic                  wr_osc;
	logic                  wr_t1;
	logic [7:0]            osc_rd;
	logic [7:0]            t1_rd;
	scss_pkg::scss_clk_ctl_t ctl_nxt;

	assign pin_v = {fast_stable_i, ost_done_i, slow_clk_i,
		fast_clk_i, sec_clk_i, prim_clk_i};

	// three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sy1_r <= '0;
			sy2_r <= '0;
			sy3_r <= '0;
		end else begin
			sy1_r <= pin_v;
			sy2_r <= sy1_r;
			sy3_r <= sy2_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < scss_pkg::PIN_N; gi = gi + 1) begin : g_pin
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					stab_r[gi] <= 1'b0;
				end else if (sy2_r[gi] == sy3_r[gi]) begin
					stab_r[gi] <= sy2_r[gi];
				end
			end
			assign rise[gi] = (sy2_r[gi] == sy3_r[gi]) & sy2_r[gi]
				& ~stab_r[gi];
		end
	endgenerate

	// mode from config
	// caught one clock after reset release so the strap never feeds a reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_done_r  <= 1'b0;
			prim_mode_o <= scss_pkg::PRIM_MODE_RST;
		end else if (!cfg_done_r) begin
			cfg_done_r  <= 1'b1;
			prim_mode_o <= cfg_prim_mode_i;
		end
	end

	// wishbone classic slave, one wait state, unmapped reads give zero
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_osc = wb_req & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == scss_pkg::OSC_CTRL_ADDR);
	assign wr_t1 = wb_req & wb_we_i & wb_sel_i[0]
		& (wb_adr_i == scss_pkg::SEC_TMR_CTRL_ADDR);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			halt_r <= scss_pkg::OSC_CTRL_RST[scss_pkg::HALT_BIT];
			freq_r <= scss_pkg::OSC_CTRL_RST[scss_pkg::FREQ_HI:
				scss_pkg::FREQ_LO];
			scs_r  <= scss_pkg::OSC_CTRL_RST[scss_pkg::SCS_HI:
				scss_pkg::SCS_LO];
		end else if (wr_osc) begin
			halt_r <= wb_dat_i[scss_pkg::HALT_BIT];
			freq_r <= wb_dat_i[scss_pkg::FREQ_HI:scss_pkg::FREQ_LO];
			scs_r  <= wb_dat_i[scss_pkg::SCS_HI:scss_pkg::SCS_LO];
		end
	end

	// secondary_timer_control: running bit is status, the rest is storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			t1ctl_r <= scss_pkg::SEC_TMR_RST;
		end else if (wr_t1) begin
			t1ctl_r <= wb_dat_i[7:0];
		end
	end

	assign st_startup = stab_r[scss_pkg::PIN_OST]
		& (state_r != scss_pkg::ST_HOLD) & (state_r != scss_pkg::ST_SLEEP)
		& (src_r == scss_pkg::SRC_PRI);
	assign st_stable = stab_r[scss_pkg::PIN_FSTB]
		& (state_r == scss_pkg::ST_PM) & (src_r == scss_pkg::SRC_INT)
		& (freq_r != scss_pkg::FREQ_DIRECT_SLOW);
	assign st_secrun = (state_r == scss_pkg::ST_PM)
		& (src_r == scss_pkg::SRC_SEC);

	always_comb begin
		osc_rd = {halt_r, freq_r, st_startup, st_stable, scs_r};
		t1_rd  = t1ctl_r;
		t1_rd[scss_pkg::SECONDARY_RUN_MODE_BIT] = st_secrun;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					scss_pkg::OSC_CTRL_ADDR:
						wb_dat_o <= {24'h000000, osc_rd};
					scss_pkg::SEC_TMR_CTRL_ADDR:
						wb_dat_o <= {24'h000000, t1_rd};
					default:
						wb_dat_o <= '0;
				endcase
			end else begin
				wb_dat_o <= '0;
			end
		end
	end

	assign wake = irq_wake_i | wdt_timeout_i;

	always_comb begin
		if (scs_r[scss_pkg::SCS_HI]) begin
			req_src = scss_pkg::SRC_INT;
		end else if (scs_r == scss_pkg::SCS_SECONDARY
			&& t1ctl_r[scss_pkg::SEC_EN_BIT]) begin
			req_src = scss_pkg::SRC_SEC;
		end else begin
			req_src = scss_pkg::SRC_PRI;
		end
	end

	// primary source with cpu running is plain sleep
	assign sleep_mode_req = !halt_r && (req_src == scss_pkg::SRC_PRI);

	// slow code takes slow source directly
	always_comb begin
		case (src_r)
			scss_pkg::SRC_PRI: new_rise = rise[scss_pkg::PIN_PRI];
			scss_pkg::SRC_SEC: new_rise = rise[scss_pkg::PIN_SEC];
			scss_pkg::SRC_INT: new_rise =
				(freq_r == scss_pkg::FREQ_DIRECT_SLOW) ?
				rise[scss_pkg::PIN_SLOW] : rise[scss_pkg::PIN_FAST];
			default: new_rise = 1'b0;
		endcase
	end

	always_comb begin
		state_nxt   = state_r;
		src_nxt     = src_r;
		pm_halt_nxt = pm_halt_r;
		cnt_nxt     = cnt_r;
		case (state_r)
			scss_pkg::ST_PRI, scss_pkg::ST_PM: begin
				if (state_r == scss_pkg::ST_PM && wake) begin
					state_nxt   = scss_pkg::ST_HOLD;
					src_nxt     = scss_pkg::SRC_PRI;
					pm_halt_nxt = 1'b0;
					cnt_nxt     = '0;
				end else if (sleep_exec_i && sleep_mode_req) begin
					state_nxt   = scss_pkg::ST_SLEEP;
					src_nxt     = scss_pkg::SRC_PRI;
					pm_halt_nxt = 1'b1;
				end else if (sleep_exec_i) begin
					state_nxt   = scss_pkg::ST_HOLD;
					src_nxt     = req_src;
					pm_halt_nxt = halt_r;
					cnt_nxt     = '0;
				end
			end
			scss_pkg::ST_HOLD: begin
				if (wake && pm_halt_r | (src_r != scss_pkg::SRC_PRI)) begin
					src_nxt     = scss_pkg::SRC_PRI;
					pm_halt_nxt = 1'b0;
					cnt_nxt     = '0;
				end else if (new_rise) begin
					// first edge opens count: 8 to 9 periods
					if (cnt_r == scss_pkg::HOLD_EDGES) begin
						cnt_nxt = '0;
						if (src_r == scss_pkg::SRC_PRI && !pm_halt_r) begin
							state_nxt = scss_pkg::ST_PRI;
						end else begin
							state_nxt = scss_pkg::ST_PM;
						end
					end else begin
						cnt_nxt = cnt_r + 4'h1;
					end
				end
			end
			scss_pkg::ST_SLEEP: begin
				if (wake) begin
					state_nxt   = scss_pkg::ST_HOLD;
					src_nxt     = scss_pkg::SRC_PRI;
					pm_halt_nxt = 1'b0;
					cnt_nxt     = '0;
				end
			end
			default: begin
				state_nxt   = scss_pkg::ST_PRI;
				src_nxt     = scss_pkg::SRC_PRI;
				pm_halt_nxt = 1'b0;
				cnt_nxt     = '0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r   <= scss_pkg::ST_PRI;
			src_r     <= scss_pkg::SRC_PRI;
			pm_halt_r <= 1'b0;
			cnt_r     <= '0;
		end else begin
			state_r   <= state_nxt;
			src_r     <= src_nxt;
			pm_halt_r <= pm_halt_nxt;
			cnt_r     <= cnt_nxt;
		end
	end

	// clock and oscillator controls, registered from present state
	always_comb begin
		ctl_nxt = '0;
		ctl_nxt.src = src_r;
		ctl_nxt.int_freq = freq_r;
		ctl_nxt.sys_clk_run = (state_r == scss_pkg::ST_PRI)
			|| (state_r == scss_pkg::ST_PM);
		ctl_nxt.cpu_clk_run = (state_r == scss_pkg::ST_PRI)
			|| (state_r == scss_pkg::ST_PM && !pm_halt_r);
		// primary on whenever it is the source, outside sleep
		ctl_nxt.prim_osc_en = (state_r != scss_pkg::ST_SLEEP)
			&& (src_r == scss_pkg::SRC_PRI);
		ctl_nxt.sec_osc_en = t1ctl_r[scss_pkg::SEC_EN_BIT]
			|| (src_r == scss_pkg::SRC_SEC
			&& state_r != scss_pkg::ST_SLEEP);
		ctl_nxt.fast_osc_en = (state_r != scss_pkg::ST_SLEEP)
			&& (src_r == scss_pkg::SRC_INT)
			&& (freq_r != scss_pkg::FREQ_DIRECT_SLOW);
		ctl_nxt.slow_osc_en = wdt_en_i || fscm_en_i
			|| ((state_r != scss_pkg::ST_SLEEP)
			&& (src_r == scss_pkg::SRC_INT)
			&& (freq_r == scss_pkg::FREQ_DIRECT_SLOW));
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clk_ctl_o <= '0;
		end else begin
			clk_ctl_o <= ctl_nxt;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_scs_reset_clear: assert property ($fell(rst_i) |-> scs_r == 2'h0)
		else $error("select field not zero after reset");

	a_src_needs_sleep: assert property (
		(state_r == scss_pkg::ST_PM && !sleep_exec_i && !wake)
		|=> $stable(src_r))
		else $error("source changed without sleep");

	a_status_one_hot: assert property (
		$onehot0({st_startup, st_stable, st_secrun}))
		else $error("more than one source status bit set");

	a_sec_req_ignored: assert property (
		(sleep_exec_i && state_r == scss_pkg::ST_PRI
		&& scs_r == scss_pkg::SCS_SECONDARY
		&& !t1ctl_r[scss_pkg::SEC_EN_BIT])
		|=> src_r != scss_pkg::SRC_SEC)
		else $error("secondary taken while disabled");

	a_hold_edge_count: assert property (
		(state_r == scss_pkg::ST_HOLD && state_nxt != scss_pkg::ST_HOLD)
		|-> cnt_r == scss_pkg::HOLD_EDGES && new_rise)
		else $error("hold left before eight edges");

	// clock gate drops two edges after sleep
	a_sleep_stop_clk: assert property (
		(state_r == scss_pkg::ST_PRI && sleep_exec_i)
		|=> ##1 !clk_ctl_o.sys_clk_run)
		else $error("system clock not stopped after sleep");

	a_sleep_all_off: assert property (
		state_r == scss_pkg::ST_SLEEP |=> !clk_ctl_o.prim_osc_en
		&& !clk_ctl_o.fast_osc_en && !clk_ctl_o.sys_clk_run)
		else $error("clock source running in sleep");

	a_slow_for_wdt: assert property (wdt_en_i |=> clk_ctl_o.slow_osc_en)
		else $error("slow source off with watchdog enabled");

	a_cpu_idle_halt: assert property (
		(state_r == scss_pkg::ST_PM && pm_halt_r)
		|=> !clk_ctl_o.cpu_clk_run)
		else $error("cpu clocked in idle mode");

	a_wake_to_prim: assert property (
		(state_r == scss_pkg::ST_SLEEP && wake) |=>
		state_r == scss_pkg::ST_HOLD && src_r == scss_pkg::SRC_PRI)
		else $error("wake did not head for primary");

	a_fast_off_slow: assert property (
		(src_r == scss_pkg::SRC_INT
		&& freq_r == scss_pkg::FREQ_DIRECT_SLOW)
		|=> !clk_ctl_o.fast_osc_en || $changed(freq_r))
		else $error("fast oscillator on while slow drives clock");

endmodule // scss_top

// *** test/scss_osc_model.sv ***
// oscillator and start-up status model facing the clock switch
`timescale 1ns/1ps

module scss_osc_model (
	input  wire scss_pkg::scss_clk_ctl_t ctl_i,        // enables from switch
	output logic                         prim_clk_o,   // primary osc
	output logic                         sec_clk_o,    // secondary osc
	output logic                         fast_clk_o,   // fast internal osc
	output logic                         slow_clk_o,   // slow internal osc
	output logic                         ost_done_o,   // start-up timer done
	output logic                         fast_stable_o // fast osc settled
);
	// a disabled oscillator stands low, so counting it would hang
	// half periods span two system clocks so the synchroniser sees each level
	initial begin
		prim_clk_o = 1'b0;
		forever #13 prim_clk_o = ctl_i.prim_osc_en & ~prim_clk_o;
	end
	initial begin
		sec_clk_o = 1'b0;
		forever #22 sec_clk_o = ctl_i.sec_osc_en & ~sec_clk_o;
	end
	initial begin
		fast_clk_o = 1'b0;
		forever #11 fast_clk_o = ctl_i.fast_osc_en & ~fast_clk_o;
	end
	initial begin
		slow_clk_o = 1'b0;
		forever #32 slow_clk_o = ctl_i.slow_osc_en & ~slow_clk_o;
	end
	// start-up timer and settling lag each enable
	initial ost_done_o = 1'b0;
	initial fast_stable_o = 1'b0;
	always @(ctl_i.prim_osc_en) ost_done_o <= #100 ctl_i.prim_osc_en;
	always @(ctl_i.fast_osc_en) fast_stable_o <= #60 ctl_i.fast_osc_en;
endmodule // scss_osc_model

// *** test/scss_top_bench.sv ***
// self-checking bench for the system clock source switch
`timescale 1ns/1ps

module scss_top_bench;
	localparam logic [7:0] A_OSC = scss_pkg::OSC_CTRL_ADDR;
	localparam logic [7:0] A_SEC = scss_pkg::SEC_TMR_CTRL_ADDR;
	logic                    clk_i, rst_i, cyc, stb, we, ack, wdt_en, fscm_en;
	logic [2:0]              ev;
	logic [3:0]              sel;
	logic [7:0]              adr, cfg, pmode;
	logic [31:0]             wdat, rdat, rq;
	logic                    pclk, sclk, fclk, lclk, ost, fst;
	scss_pkg::scss_clk_ctl_t ctl;
	int                      err_count, check_count, cyc_cnt, lo;

	scss_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.cfg_prim_mode_i(cfg), .sleep_exec_i(ev[0]), .irq_wake_i(ev[1]),
		.wdt_timeout_i(ev[2]), .wdt_en_i(wdt_en), .fscm_en_i(fscm_en),
		.prim_clk_i(pclk), .sec_clk_i(sclk), .fast_clk_i(fclk),
		.slow_clk_i(lclk), .ost_done_i(ost), .fast_stable_i(fst),
		.prim_mode_o(pmode), .clk_ctl_o(ctl));

	scss_osc_model osc (.ctl_i(ctl), .prim_clk_o(pclk), .sec_clk_o(sclk),
		.fast_clk_o(fclk), .slow_clk_o(lclk), .ost_done_o(ost),
		.fast_stable_o(fst));

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// one classic cycle; request held until ack is sampled high
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1);
		rq = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// the slave answers on the edge after it takes the request
		chk(n, 32'h2, "ack delay");
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string s);
		wb(1'b0, a, 8'h00);
		chk(rq, {24'h0, e}, s);
	endtask

	// pulse sleep or a wake event, then count cycles with the gate shut
	task automatic go(input logic [2:0] e);
		@(posedge clk_i);
		ev <= e;
		@(posedge clk_i);
		ev <= 3'h0;
		lo = 0;
		repeat (3) begin
			@(posedge clk_i);
			if (ctl.sys_clk_run === 1'b0) lo++;
		end
		while (ctl.sys_clk_run !== 1'b1 && lo < 300) begin
			@(posedge clk_i);
			lo++;
		end
	endtask

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_count++;
			$display("BAD %0t timeout", $time);
			test_done();
		end
	end

	initial begin
		{rst_i, cyc, stb, we, adr, sel, wdat, ev} = '0;
		rst_i = 1'b1;
		{wdt_en, fscm_en} = 2'h0;
		cfg = 8'h5A;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// start-up timer still counting right after reset
		rchk(A_OSC, 8'h00, "early osc");
		cfg <= 8'hA5;
		repeat (40) @(posedge clk_i);
		chk(pmode, 8'h5A, "mode");
		rchk(A_OSC, 8'h08, "osc");
		rchk(A_SEC, 8'h00, "sec");
		wb(1'b1, 8'h08, 8'hFF);
		rchk(8'h08, 8'h00, "unmapped");
		$display("test 1 done");
		wb(1'b1, A_SEC, 8'h4F);
		rchk(A_SEC, 8'h0F, "sec ro");
		wb(1'b1, A_OSC, 8'h01);
		rchk(A_OSC, 8'h09, "scs rw");
		chk({ctl.sys_clk_run, ctl.src}, 3'h4, "no switch");
		go(3'h1);
		// 8 to 9 secondary periods of 8.8 cycles, plus sync lag
		chk(lo >= 70 && lo <= 86, 1'b1, "hold");
		chk({ctl.src, ctl.cpu_clk_run, ctl.prim_osc_en}, 4'h6, "secondary_run_mode");
		rchk(A_SEC, 8'h4F, "secondary_run_mode bit");
		rchk(A_OSC, 8'h01, "one status");
		go(3'h2);
		chk({ctl.src, ctl.sys_clk_run, ctl.prim_osc_en}, 4'h3, "irq");
		$display("test 2 done");
		wb(1'b1, A_OSC, 8'hF2);
		go(3'h1);
		chk({ctl.src, ctl.cpu_clk_run, ctl.fast_osc_en}, 4'h9, "int");
		chk({ctl.int_freq, ctl.prim_osc_en}, 4'hE, "fast");
		rchk(A_OSC, 8'hF6, "stable");
		wb(1'b1, A_OSC, 8'h83);
		repeat (2) @(posedge clk_i);
		chk({ctl.int_freq, ctl.fast_osc_en}, 4'h0, "slow");
		rchk(A_OSC, 8'h83, "unstable");
		go(3'h4);
		chk({ctl.src, ctl.cpu_clk_run}, 3'h1, "wdt");
		$display("test 3 done");
		wdt_en <= 1'b1;
		wb(1'b1, A_SEC, 8'h00);
		wb(1'b1, A_OSC, 8'h01);
		go(3'h1);
		chk({ctl.sys_clk_run, ctl.cpu_clk_run, ctl.prim_osc_en,
			ctl.sec_osc_en, ctl.fast_osc_en, ctl.slow_osc_en}, 6'h01,
			"sleep");
		go(3'h2);
		chk({ctl.src, ctl.sys_clk_run}, 3'h1, "sleep wake");
		wdt_en <= 1'b0;
		$display("test 4 done");
		wb(1'b1, A_OSC, 8'h80);
		go(3'h1);
		chk({ctl.sys_clk_run, ctl.cpu_clk_run, ctl.prim_osc_en}, 3'h5,
			"primary_idle_mode");
		go(3'h2);
		// secondary started before the sleep that selects it
		wb(1'b1, A_SEC, 8'h08);
		wb(1'b1, A_OSC, 8'h81);
		go(3'h1);
		chk({ctl.src, ctl.cpu_clk_run, ctl.sec_osc_en}, 4'h5, "secondary_idle_mode");
		go(3'h2);
		$display("test 5 done");
		// reset in mid-run from secondary idle
		go(3'h1);
		chk({ctl.src, ctl.cpu_clk_run}, 3'h2, "secondary_idle_mode again");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(A_OSC, 8'h00, "reset osc");
		chk({ctl.src, ctl.sys_clk_run, ctl.cpu_clk_run, ctl.prim_osc_en,
			ctl.slow_osc_en}, 6'h0E, "reset run");
		rchk(A_SEC, 8'h00, "reset sec");
		fscm_en <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(ctl.slow_osc_en, 1'b1, "fail-safe slow");
		fscm_en <= 1'b0;
		$display("test 6 done");
		test_done();
	end
endmodule // scss_top_bench
